// file: core/dfc_cmd_reg.sv
`timescale 1ns/1ps
`include "dfc_defs.svh"

module dfc_cmd_reg (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // load controls
  input wire logic load_command_exact,
  input wire logic load_command_ones,
  input wire logic load_command_zeros,
  input wire logic force_idle,
  input wire logic [17:0] io_bus,
  // stored word
  output logic [`DFC_CMD_W-1:0] cmd_word
);

  logic [`DFC_CMD_W-1:0] bus_bits;

  assign bus_bits = io_bus[`DFC_CMD_W-1:0];

  // ----------------------------------------------------------------
  // exact, ones-only and zeros-only loading
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_word <= `DFC_CMD_RESET;
    end else if (force_idle) begin
      cmd_word <= `DFC_CMD_RESET;
    end else if (load_command_exact) begin
      cmd_word <= bus_bits;
    end else if (load_command_ones) begin
      cmd_word <= cmd_word | bus_bits;
    end else if (load_command_zeros) begin
      cmd_word <= cmd_word & bus_bits;
    end
  end

endmodule // dfc_cmd_reg

// file: core/dfc_ctrl.sv
`timescale 1ns/1ps
`include "dfc_defs.svh"

module dfc_ctrl #(
  parameter int SECTOR_WORDS = `DFC_SECTOR_WORDS,
  parameter int INIT_BUSY_CYC = `DFC_INIT_BUSY_CYC,
  parameter int SEEK_TMO_CYC = `DFC_SEEK_TMO_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // host instructions
  input wire logic load_command_exact,
  input wire logic load_command_ones,
  input wire logic load_command_zeros,
  input wire logic continue_transfer_instr,
  input wire logic controller_clear_flags_instr,
  input wire logic clear_all_flags_instr,
  input wire logic console_reset,
  input wire logic load_length_counter_instr,
  input wire logic load_address_instr,
  input wire logic clear_length_counter,
  input wire logic [17:0] io_bus,
  // data channel
  input wire logic word_strobe,
  input wire logic [17:0] mem_word,
  input wire logic [17:0] disk_word,
  input wire logic sector_start,
  input wire logic sector_word_done,
  input wire logic parity_done,
  // drive side
  input wire logic format_switch,
  input wire logic heads_on_cylinder,
  input wire logic seek_done,
  input wire logic seek_fail,
  input wire logic recal_done,
  // outputs
  output logic busy,
  output logic xfer_active,
  output logic zero_fill,
  output logic [2:0] unit_select_field,
  output logic [2:0] function_code_field,
  output logic go,
  output logic attention_irq_disable,
  output logic done_error_irq_disable,
  output logic flag_a,
  output logic compare_mismatch_signal,
  output logic seek_incomplete_status,
  output logic selected_unit_ready,
  output logic unit_attention,
  output logic recal_to_zero,
  output logic header_xfer,
  output logic format_mode,
  output logic [17:0] current_address_counter,
  output logic [17:0] length_count
);

  initial begin
    if (INIT_BUSY_CYC < 1 || SEEK_TMO_CYC < 1 || SECTOR_WORDS < 2) begin
      $error("dfc_ctrl: bad parameter");
    end
  end

  // ----------------------------------------------------------------
  // command register
  // ----------------------------------------------------------------
  logic [`DFC_CMD_W-1:0] cmd_word;
  logic force_idle;
  logic any_load;
  dfc_pkg::dfc_func_t func;

  assign force_idle = clear_all_flags_instr | controller_clear_flags_instr
    | console_reset;
  assign any_load = load_command_exact | load_command_ones
    | load_command_zeros;

  dfc_cmd_reg u_cmd (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load_command_exact(load_command_exact),
    .load_command_ones(load_command_ones),
    .load_command_zeros(load_command_zeros),
    .force_idle(force_idle),
    .io_bus(io_bus),
    .cmd_word(cmd_word)
  );

  assign func = dfc_pkg::dfc_func_t'(
    cmd_word[`DFC_FUNC_MSB:`DFC_FUNC_LSB]);

  function automatic logic is_exec(input dfc_pkg::dfc_func_t f);
    is_exec = !(f == dfc_pkg::DFC_IDLE || f == dfc_pkg::DFC_RECAL
      || f == dfc_pkg::DFC_SEEK);
  endfunction

  function automatic logic is_read(input dfc_pkg::dfc_func_t f);
    is_read = (f == dfc_pkg::DFC_READ || f == dfc_pkg::DFC_READ_ALL);
  endfunction

  // ----------------------------------------------------------------
  // mirrored command fields
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_select_field <= 3'h0;
      function_code_field <= 3'h0;
      go <= 1'b0;
      attention_irq_disable <= 1'b0;
      done_error_irq_disable <= 1'b0;
      format_mode <= 1'b0;
      header_xfer <= 1'b0;
    end else begin
      unit_select_field <= cmd_word[`DFC_UNIT_MSB:`DFC_UNIT_LSB];
      function_code_field <= cmd_word[`DFC_FUNC_MSB:`DFC_FUNC_LSB];
      go <= cmd_word[`DFC_GO_BIT];
      attention_irq_disable <= !cmd_word[`DFC_ATD_BIT];
      done_error_irq_disable <= !cmd_word[`DFC_DED_BIT];
      format_mode <= (func == dfc_pkg::DFC_WRITE_ALL) && format_switch;
      header_xfer <= (func == dfc_pkg::DFC_READ_ALL)
        || ((func == dfc_pkg::DFC_WRITE_ALL) && !format_switch);
    end
  end

  // ----------------------------------------------------------------
  // word count and current address
  // ----------------------------------------------------------------
  logic wc_overflow;
  logic word_xfer;

  assign word_xfer = word_strobe && xfer_active && !zero_fill
    && !wc_overflow;

  dfc_len_counter #(
    .WIDTH(`DFC_WC_W)
  ) u_wc (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(load_length_counter_instr),
    .clear(clear_length_counter || force_idle),
    .incr(word_xfer),
    .load_value(io_bus),
    .count(length_count),
    .overflow(wc_overflow)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      current_address_counter <= 18'h00000;
    end else if (load_address_instr) begin
      current_address_counter <= io_bus;
    end else if (word_xfer) begin
      current_address_counter <= current_address_counter + 18'h00001;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  dfc_pkg::dfc_state_t state;
  logic start;
  logic start_req;
  logic [31:0] hold_cnt;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_req <= 1'b0;
    end else begin
      start_req <= (any_load || continue_transfer_instr) && !force_idle;
    end
  end

  assign start = start_req && !busy && !force_idle;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= dfc_pkg::DFC_ST_IDLE;
      hold_cnt <= 32'h00000000;
      busy <= 1'b0;
      xfer_active <= 1'b0;
      zero_fill <= 1'b0;
    end else if (force_idle) begin
      state <= dfc_pkg::DFC_ST_IDLE;
      busy <= 1'b0;
      xfer_active <= 1'b0;
      zero_fill <= 1'b0;
    end else begin
      case (state)
        dfc_pkg::DFC_ST_IDLE: begin
          if (start && cmd_word[`DFC_GO_BIT]) begin
            busy <= 1'b1;
            if (is_exec(func)) begin
              state <= dfc_pkg::DFC_ST_XFER;
            end else begin
              hold_cnt <= 32'h00000000;
              state <= dfc_pkg::DFC_ST_INIT_HOLD;
            end
          end
        end
        dfc_pkg::DFC_ST_INIT_HOLD: begin
          hold_cnt <= hold_cnt + 32'h00000001;
          if (hold_cnt >= 32'(INIT_BUSY_CYC - 1)) begin
            busy <= 1'b0;
            state <= dfc_pkg::DFC_ST_IDLE;
          end
        end
        dfc_pkg::DFC_ST_XFER: begin
          if (sector_start) begin
            xfer_active <= 1'b1;
          end
          if (wc_overflow && xfer_active && sector_word_done) begin
            state <= dfc_pkg::DFC_ST_PARITY;
          end else if (wc_overflow && xfer_active) begin
            state <= dfc_pkg::DFC_ST_TAIL;
            zero_fill <= !is_read(func)
              && func != dfc_pkg::DFC_WRITE_CHECK;
          end
        end
        dfc_pkg::DFC_ST_TAIL: begin
          if (sector_word_done) begin
            state <= dfc_pkg::DFC_ST_PARITY;
            zero_fill <= 1'b0;
          end
        end
        dfc_pkg::DFC_ST_PARITY: begin
          if (parity_done) begin
            busy <= 1'b0;
            xfer_active <= 1'b0;
            state <= dfc_pkg::DFC_ST_IDLE;
          end
        end
        default: begin
          state <= dfc_pkg::DFC_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flag_a and write check error
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_a <= 1'b0;
    end else if (state == dfc_pkg::DFC_ST_PARITY && parity_done) begin
      flag_a <= 1'b1;
    end else if (force_idle || start) begin
      flag_a <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_mismatch_signal <= 1'b0;
    end else if (word_xfer && func == dfc_pkg::DFC_WRITE_CHECK
      && mem_word != disk_word) begin
      compare_mismatch_signal <= 1'b1;
    end else if (force_idle || start) begin
      compare_mismatch_signal <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // seek and recalibrate status
  // ----------------------------------------------------------------
  logic seek_pending;
  logic recal_pending;
  logic [31:0] seek_cnt;
  logic seek_timeout;

  assign seek_timeout = seek_pending && seek_cnt >= 32'(SEEK_TMO_CYC - 1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seek_pending <= 1'b0;
      recal_pending <= 1'b0;
      seek_cnt <= 32'h00000000;
      unit_attention <= 1'b0;
      seek_incomplete_status <= 1'b0;
      selected_unit_ready <= 1'b0;
      recal_to_zero <= 1'b0;
    end else if (force_idle) begin
      seek_pending <= 1'b0;
      recal_pending <= 1'b0;
      recal_to_zero <= 1'b0;
    end else if (state == dfc_pkg::DFC_ST_IDLE && start
      && cmd_word[`DFC_GO_BIT] && func == dfc_pkg::DFC_SEEK) begin
      if (!heads_on_cylinder) begin
        unit_attention <= 1'b0;
        seek_pending <= 1'b1;
        seek_cnt <= 32'h00000000;
        selected_unit_ready <= 1'b0;
      end
    end else if (state == dfc_pkg::DFC_ST_IDLE && start
      && cmd_word[`DFC_GO_BIT] && func == dfc_pkg::DFC_RECAL) begin
      recal_pending <= 1'b1;
      recal_to_zero <= 1'b1;
      selected_unit_ready <= 1'b0;
    end else if (recal_pending && recal_done) begin
      recal_pending <= 1'b0;
      recal_to_zero <= 1'b0;
      unit_attention <= 1'b1;
      selected_unit_ready <= 1'b1;
      seek_incomplete_status <= 1'b0;
    end else if (seek_pending) begin
      seek_cnt <= seek_cnt + 32'h00000001;
      if (seek_fail || seek_timeout) begin
        seek_pending <= 1'b0;
        unit_attention <= 1'b1;
        seek_incomplete_status <= 1'b1;
      end else if (seek_done) begin
        seek_pending <= 1'b0;
        unit_attention <= 1'b1;
        selected_unit_ready <= 1'b1;
      end
    end
  end

endmodule // dfc_ctrl

// file: core/dfc_defs.svh
`ifndef DFC_DEFS_SVH
`define DFC_DEFS_SVH

// ----------------------------------------------------------------
// command word field positions
// ----------------------------------------------------------------
`define DFC_UNIT_LSB 0
`define DFC_UNIT_MSB 2
`define DFC_FUNC_LSB 3
`define DFC_FUNC_MSB 5
`define DFC_DED_BIT 6
`define DFC_ATD_BIT 7
`define DFC_GO_BIT 8
`define DFC_CMD_W 9
`define DFC_CMD_RESET 9'h000

// ----------------------------------------------------------------
// counters and sizes
// ----------------------------------------------------------------
`define DFC_WC_W 18
`define DFC_SECTOR_WORDS 256
`define DFC_HDR_WORDS 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DFC_CLK_NS 20
`define DFC_INIT_BUSY_NS 4000
`define DFC_INIT_BUSY_CYC ((`DFC_INIT_BUSY_NS) / (`DFC_CLK_NS))
`define DFC_SEEK_TMO_MS 100
`define DFC_SEEK_TMO_CYC \
  ((`DFC_SEEK_TMO_MS) * 1000000 / (`DFC_CLK_NS))

`endif

// file: core/dfc_len_counter.sv
`timescale 1ns/1ps
`include "dfc_defs.svh"

module dfc_len_counter #(
  parameter int WIDTH = `DFC_WC_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // controls
  input wire logic load,
  input wire logic clear,
  input wire logic incr,
  input wire logic [WIDTH-1:0] load_value,
  // state
  output logic [WIDTH-1:0] count,
  output logic overflow
);

  initial begin
    if (WIDTH < 2) begin
      $error("dfc_len_counter: WIDTH too small");
    end
  end

  // ----------------------------------------------------------------
  // two's complement up counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      overflow <= 1'b0;
    end else if (clear) begin
      count <= '0;
      overflow <= 1'b0;
    end else if (load) begin
      count <= load_value;
      overflow <= 1'b0;
    end else if (incr && !overflow) begin
      count <= count + 1'b1;
      overflow <= &count;
    end
  end

endmodule // dfc_len_counter

// file: core/dfc_pkg.sv
package dfc_pkg;

  typedef enum logic [2:0] {
    DFC_IDLE,
    DFC_READ,
    DFC_WRITE,
    DFC_RECAL,
    DFC_SEEK,
    DFC_READ_ALL,
    DFC_WRITE_ALL,
    DFC_WRITE_CHECK
  } dfc_func_t;

  typedef enum {
    DFC_ST_IDLE,
    DFC_ST_INIT_HOLD,
    DFC_ST_XFER,
    DFC_ST_TAIL,
    DFC_ST_PARITY
  } dfc_state_t;

endpackage

// file: verif/dfc_ctrl_checker.sv
`timescale 1ns/1ps
// ------------------------------------------
// port checker
// ------------------------------------------
module dfc_ctrl_checker #(
  parameter int INIT_BUSY_CYC = 200
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // instructions
  input wire logic load_command_exact,
  input wire logic load_command_ones,
  input wire logic load_command_zeros,
  input wire logic controller_clear_flags_instr,
  input wire logic clear_all_flags_instr,
  input wire logic console_reset,
  input wire logic load_length_counter_instr,
  input wire logic clear_length_counter,
  input wire logic [17:0] io_bus,
  // data channel
  input wire logic word_strobe,
  input wire logic parity_done,
  // state
  input wire logic busy,
  input wire logic xfer_active,
  input wire logic [2:0] unit_select_field,
  input wire logic [2:0] function_code_field,
  input wire logic go,
  input wire logic attention_irq_disable,
  input wire logic done_error_irq_disable,
  input wire logic flag_a,
  input wire logic [17:0] current_address_counter,
  input wire logic [17:0] length_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [8:0] cw;
  logic [15:0] bcnt;
  assign cw = {go, !attention_irq_disable, !done_error_irq_disable,
    function_code_field, unit_select_field};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt <= '0;
    end else begin
      bcnt <= busy ? bcnt + 16'h1 : '0;
    end
  end
  property p_exact;
    $past(load_command_exact, 2) |-> cw == $past(io_bus[8:0], 2);
  endproperty
  a_exact: assert property (p_exact) else $error("exact load");
  property p_ones;
    $past(load_command_ones, 2) && !$past(load_command_exact, 2)
      |-> cw == ($past(cw) | $past(io_bus[8:0], 2));
  endproperty
  a_ones: assert property (p_ones) else $error("ones load");
  property p_zeros;
    $past(load_command_zeros, 2) && !$past(load_command_exact, 2)
      && !$past(load_command_ones, 2)
      |-> cw == ($past(cw) & $past(io_bus[8:0], 2));
  endproperty
  a_zeros: assert property (p_zeros) else $error("zeros load");
  property p_init_busy;
    $fell(busy) && function_code_field inside {3'h0, 3'h3, 3'h4}
      |-> bcnt == INIT_BUSY_CYC;
  endproperty
  a_init_busy: assert property (p_init_busy) else $error("busy time");
  property p_done;
    $rose(flag_a) |-> $fell(busy) && $past(parity_done);
  endproperty
  a_done: assert property (p_done) else $error("flag_a");
  property p_count;
    $past(word_strobe && xfer_active && length_count != 18'h00000
      && !load_length_counter_instr && !clear_length_counter)
      |-> length_count == $past(length_count) + 18'h1
      && current_address_counter == $past(current_address_counter) + 18'h1;
  endproperty
  a_count: assert property (p_count) else $error("word count");
  property p_wc_load;
    $past(load_length_counter_instr) |-> length_count == $past(io_bus);
  endproperty
  a_wc_load: assert property (p_wc_load) else $error("count load");
  property p_idle;
    $past(clear_all_flags_instr || controller_clear_flags_instr
      || console_reset, 2) |-> function_code_field == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle force");
endmodule // dfc_ctrl_checker

bind dfc_ctrl dfc_ctrl_checker #(.INIT_BUSY_CYC(INIT_BUSY_CYC))
  dfc_ctrl_checker_inst (.core_clk, .rst_n, .load_command_exact,
  .load_command_ones, .load_command_zeros, .controller_clear_flags_instr,
  .clear_all_flags_instr, .console_reset, .load_length_counter_instr,
  .clear_length_counter, .io_bus, .word_strobe, .parity_done, .busy,
  .xfer_active, .unit_select_field, .function_code_field, .go,
  .attention_irq_disable, .done_error_irq_disable, .flag_a,
  .current_address_counter, .length_count);

// file: verif/dfc_drive_model.sv
`timescale 1ns/1ps
module dfc_drive_model #(
  parameter int SECT = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic xfer_active,
  input wire logic slow,
  input wire logic [2:0] func,
  output logic sector_start,
  output logic word_strobe,
  output logic sector_word_done,
  output logic parity_done,
  output logic seek_done,
  output logic seek_fail,
  output logic recal_done
);
  logic [2:0] ph;
  logic [7:0] n;
  logic tog, bq;
  logic [8:0] dly;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= '0;
      n <= '0;
      tog <= 1'b0;
      {sector_start, word_strobe, sector_word_done, parity_done} <= '0;
    end else begin
      {sector_start, word_strobe, sector_word_done, parity_done} <= '0;
      case (ph)
        3'h0: if (busy && func inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7}) begin
          sector_start <= 1'b1;
          n <= '0;
          ph <= 3'h1;
        end
        3'h1: if (n == SECT) begin
          sector_word_done <= 1'b1;
          ph <= 3'h2;
        end else begin
          tog <= ~tog;
          if (tog) begin
            n <= n + 8'h1;
            word_strobe <= xfer_active;
          end
        end
        3'h2: begin
          parity_done <= 1'b1;
          ph <= 3'h3;
        end
        default: ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bq <= 1'b0;
      dly <= '0;
      {seek_done, seek_fail, recal_done} <= '0;
    end else begin
      bq <= busy;
      if (busy && !bq && func inside {3'h3, 3'h4}) dly <= 9'd250;
      else if (dly != 9'd0) dly <= dly - 9'd1;
      seek_done <= dly == 9'd1 && func == 3'h4 && !slow;
      seek_fail <= dly == 9'd1 && func == 3'h4 && slow;
      recal_done <= dly == 9'd1 && func == 3'h3;
    end
  end
endmodule // dfc_drive_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk, rst_n, format_switch, slow, hoc;
  logic [9:0] ins;
  logic [17:0] io_bus, mem_word, disk_word, a, current_address_counter;
  logic [17:0] length_count;
  logic busy, xfer_active, zero_fill, go, attention_irq_disable, flag_a;
  logic done_error_irq_disable, compare_mismatch_signal, unit_attention;
  logic seek_incomplete_status, selected_unit_ready, header_xfer;
  logic recal_to_zero, format_mode, zf, hx, fm;
  logic sector_start, word_strobe, sector_word_done, parity_done;
  logic seek_done, seek_fail, recal_done;
  logic [2:0] unit_select_field, function_code_field;
  logic [8:0] cw, v, exp;
  int n_mismatch, compares, cycles, i, k, f, nw, cnt, r;
  assign cw = {go, ~attention_irq_disable, ~done_error_irq_disable,
    function_code_field, unit_select_field};
  dfc_ctrl #(.SECTOR_WORDS(4), .INIT_BUSY_CYC(200), .SEEK_TMO_CYC(400))
    dfc_ctrl_inst (.core_clk, .rst_n, .load_command_exact(ins[0]),
    .load_command_ones(ins[1]), .load_command_zeros(ins[2]),
    .continue_transfer_instr(ins[3]), .controller_clear_flags_instr(ins[4]),
    .clear_all_flags_instr(ins[5]), .console_reset(ins[6]),
    .load_length_counter_instr(ins[7]), .load_address_instr(ins[8]),
    .clear_length_counter(ins[9]), .io_bus, .word_strobe, .mem_word,
    .disk_word, .sector_start, .sector_word_done, .parity_done,
    .format_switch, .heads_on_cylinder(hoc), .seek_done, .seek_fail,
    .recal_done, .busy, .xfer_active, .zero_fill, .unit_select_field,
    .function_code_field, .go, .attention_irq_disable,
    .done_error_irq_disable, .flag_a, .compare_mismatch_signal,
    .seek_incomplete_status, .selected_unit_ready, .unit_attention,
    .recal_to_zero, .header_xfer, .format_mode,
    .current_address_counter, .length_count);
  dfc_drive_model #(.SECT(4)) dfc_drive_model_inst (.core_clk, .rst_n,
    .busy, .xfer_active, .slow, .func(function_code_field), .sector_start,
    .word_strobe, .sector_word_done, .parity_done, .seek_done, .seek_fail,
    .recal_done);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] want);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic instr(input int kk, input logic [17:0] val);
    io_bus = val;
    ins[kk] = 1'b1;
    @(negedge core_clk);
    ins = '0;
    @(negedge core_clk);
  endtask
  task automatic run(input int fc, input logic cont);
    if (cont) instr(3, 18'h0);
    else instr(0, {9'h0, 1'b1, 2'b11, 3'(fc), 3'h5});
    {zf, hx, fm} = '0;
    cnt = 0;
    while (busy && cnt < 5000) begin
      @(negedge core_clk);
      cnt++;
      zf |= zero_fill;
      hx |= header_xfer;
      fm |= format_mode;
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  initial begin
    {rst_n, format_switch, slow, hoc, ins, io_bus, mem_word, disk_word} = '0;
    {n_mismatch, compares, cycles} = '0;
    exp = '0;
    r = $urandom(6);
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check(cw, 18'h0);
    check(busy, 1'b0);
    for (i = 0; i < 24; i++) begin
      k = $urandom % 3;
      v = (i == 0) ? 9'h0FF : {1'b0, 8'($urandom)};
      exp = (k == 0) ? v : (k == 1) ? (exp | v) : (exp & v);
      instr(k, {9'h0, v});
      @(negedge core_clk);
      check(cw, exp);
    end
    for (f = 0; f < 8; f++) begin
      nw = 1 + $urandom % 6;
      a = 18'($urandom);
      mem_word = 18'($urandom);
      disk_word = (f == 7) ? mem_word ^ 18'h00004 : mem_word;
      format_switch = 1'($urandom);
      instr(7, 18'(-nw));
      instr(8, a);
      run(f, 1'b0);
      if (f == 0 || f == 3 || f == 4) begin
        check(18'(cnt), 18'h000C8);
        if (f != 0) begin
          check(recal_to_zero, f == 3);
          check(unit_attention, 1'b0);
          repeat (260) @(negedge core_clk);
          check(unit_attention, 1'b1);
          check(selected_unit_ready, 1'b1);
          check(recal_to_zero, 1'b0);
        end
      end else begin
        check(flag_a, 1'b1);
        check(xfer_active, 1'b0);
        check(current_address_counter, a + 18'(nw));
        check(length_count, 18'h0);
        check(compare_mismatch_signal, f == 7);
        check(zf, (f == 2 || f == 6) && nw % 4 != 0);
        check(hx, f == 5 || (f == 6 && !format_switch));
        check(fm, f == 6 && format_switch);
      end
    end
    instr(7, 18'h3FFFD);
    run(7, 1'b1);
    check(flag_a, 1'b1);
    check(current_address_counter, a + 18'(nw) + 18'h00003);
    check(compare_mismatch_signal, 1'b1);
    slow = 1'b1;
    run(4, 1'b0);
    repeat (260) @(negedge core_clk);
    check(seek_incomplete_status, 1'b1);
    slow = 1'b0;
    hoc = 1'b1;
    run(4, 1'b0);
    check(unit_attention, 1'b1);
    hoc = 1'b0;
    for (k = 4; k < 7; k++) begin
      instr(0, 18'h00020);
      instr(k, 18'h0);
      @(negedge core_clk);
      check(function_code_field, 3'h0);
    end
    instr(7, 18'h3FFFF);
    instr(9, 18'h0);
    check(length_count, 18'h0);
    wrap_up;
  end
endmodule // tb_top
